// ==== core/atc_pkg.sv ====
package atc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_MODE_CFG = 8'h01;
  localparam logic [7:0] ADDR_OUT_REF_CFG = 8'h02;
  localparam logic [7:0] ADDR_CLAMP_CFG = 8'h03;
  localparam logic [7:0] ADDR_LINE_CFG = 8'h04;
  localparam logic [7:0] ADDR_CYCLE_RESET = 8'h05;
  localparam logic [7:0] ADDR_STATUS = 8'h06;
  localparam logic [7:0] ADDR_COMPAT_MODE = 8'h07;

  // ==========================================================
  // Field positions
  localparam int MODE_CDS_BIT = 1;
  localparam int MODE_SINGLE_BIT = 2;
  localparam int MODE_COMPAT_BIT = 7;
  localparam int OUT_LAT_LSB = 6;
  localparam int CLAMP_CODE_LSB = 0;
  localparam int CLAMP_SHIFT_LSB = 4;
  localparam int CLAMP_CHAN_LSB = 6;
  localparam int LINE_SEQ_BIT = 0;
  localparam int LINE_ACYC_BIT = 1;
  localparam int LINE_INTM_LSB = 2;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [1:0] OUT_LAT_RST = 2'h0;
  localparam logic [5:0] OUT_REF_RST = 6'h20;
  localparam logic [3:0] CLAMP_CODE_RST = 4'hF;
  localparam logic [1:0] SHIFT_RST = 2'h1;
  localparam logic [1:0] CHAN_RST = 2'h0;
  localparam logic [3:0] LINE_CFG_RST = 4'h0;
  localparam logic [2:0] COMPAT_MODE_RST = 3'h1;
  localparam logic [2:0] COMPAT_MODE_LONG = 3'h3;

  // ==========================================================
  // Cycle counts
  localparam logic [4:0] LAT_NORM_BASE = 5'h07;
  localparam logic [4:0] LAT_COMPAT_BASE = 5'h10;
  localparam logic [4:0] LAT_LONG_0 = 5'h17;
  localparam logic [4:0] LAT_LONG_1 = 5'h1A;
  localparam logic [4:0] LAT_LONG_2 = 5'h1D;
  localparam logic [4:0] LAT_LONG_3 = 5'h1F;
  localparam logic [1:0] RS_BASE_TAP = 2'h1;
  localparam int LAT_DEPTH = 32;

  typedef enum logic [1:0] {ATC_RED, ATC_GREEN, ATC_BLUE, ATC_RSVD} atc_chan_t;

  // Whole clock part of the latency; compat adds half a clock
  function automatic logic [4:0] atc_latency(input logic [1:0] sel, input logic compat, input logic long_mode);
    logic [4:0] r;
    r = LAT_NORM_BASE + {3'h0, sel};
    if (compat && long_mode) begin
      unique case (sel)
        2'h0: r = LAT_LONG_0;
        2'h1: r = LAT_LONG_1;
        2'h2: r = LAT_LONG_2;
        2'h3: r = LAT_LONG_3;
      endcase
    end else if (compat) begin
      r = LAT_COMPAT_BASE + {2'h0, sel, 1'b0};
    end
    return r;
  endfunction

endpackage

// ==== core/atc_delay_line.sv ====
`timescale 1ns/1ps
`default_nettype none
module atc_delay_line
  import atc_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = LAT_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clr_i,
  input wire logic [4:0] tap_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] data_o
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [4:0] idx;

  assign idx = tap_i - 5'h02;

  // ==========================================================
  // Shift chain, output registered at the selected depth
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (clr_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      mem_q[0] <= data_i;
      for (int i = 1; i < DEPTH; i++) begin
        mem_q[i] <= mem_q[i-1];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_o <= '0;
    end else if (clr_i) begin
      data_o <= '0;
    end else begin
      data_o <= mem_q[idx];
    end
  end

endmodule
`default_nettype wire

// ==== core/atc_timing_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module atc_timing_regs
  import atc_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [DATA_W-1:0] adc_data_i,
  output logic [DATA_W-1:0] out_data_o,
  output logic half_period_o,
  input wire logic pixel_sample_strobe_i,
  output logic reset_sample_o,
  input wire logic cycle_pulse_i,
  output logic [1:0] gain_set_sel_o,
  output logic [2:0] channel_enable_o,
  output logic [3:0] clamp_reference_code_o,
  output logic correlated_sampling_o
);

  // ==========================================================
  // Decode
  logic wr_soft, wr_mode, wr_out, wr_clamp, wr_line, wr_cyc, wr_cmode;

  assign wr_soft = reg_we_i && (reg_addr_i == ADDR_SOFT_RESET);
  assign wr_mode = reg_we_i && (reg_addr_i == ADDR_MODE_CFG);
  assign wr_out = reg_we_i && (reg_addr_i == ADDR_OUT_REF_CFG);
  assign wr_clamp = reg_we_i && (reg_addr_i == ADDR_CLAMP_CFG);
  assign wr_line = reg_we_i && (reg_addr_i == ADDR_LINE_CFG);
  assign wr_cyc = reg_we_i && (reg_addr_i == ADDR_CYCLE_RESET);
  assign wr_cmode = reg_we_i && (reg_addr_i == ADDR_COMPAT_MODE);

  // ==========================================================
  // Configuration registers
  logic [7:0] mode_q;
  logic [5:0] out_ref_q;
  logic [1:0] lat_q;
  logic [3:0] clamp_q;
  logic [1:0] shift_q;
  logic [1:0] chan_q;
  logic [3:0] line_q;
  logic [2:0] cmode_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= MODE_CFG_RST;
    end else if (wr_soft) begin
      mode_q <= MODE_CFG_RST;
    end else if (wr_mode) begin
      mode_q <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_ref_q <= OUT_REF_RST;
      lat_q <= OUT_LAT_RST;
    end else if (wr_soft) begin
      out_ref_q <= OUT_REF_RST;
      lat_q <= OUT_LAT_RST;
    end else if (wr_out) begin
      out_ref_q <= reg_wdata_i[5:0];
      lat_q <= reg_wdata_i[OUT_LAT_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clamp_q <= CLAMP_CODE_RST;
      shift_q <= SHIFT_RST;
      chan_q <= CHAN_RST;
    end else if (wr_soft) begin
      clamp_q <= CLAMP_CODE_RST;
      shift_q <= SHIFT_RST;
      chan_q <= CHAN_RST;
    end else if (wr_clamp) begin
      clamp_q <= reg_wdata_i[CLAMP_CODE_LSB +: 4];
      shift_q <= reg_wdata_i[CLAMP_SHIFT_LSB +: 2];
      chan_q <= reg_wdata_i[CLAMP_CHAN_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_q <= LINE_CFG_RST;
      cmode_q <= COMPAT_MODE_RST;
    end else if (wr_soft) begin
      line_q <= LINE_CFG_RST;
      cmode_q <= COMPAT_MODE_RST;
    end else begin
      if (wr_line) begin
        line_q <= reg_wdata_i[3:0];
      end
      if (wr_cmode) begin
        cmode_q <= reg_wdata_i[2:0];
      end
    end
  end

  // ==========================================================
  // Mode decode
  logic compat, correlated_sampling, line_seq, acyc_on, single_eff, rs_active;
  logic [1:0] chan_eff;

  assign compat = mode_q[MODE_COMPAT_BIT];
  assign correlated_sampling = mode_q[MODE_CDS_BIT];
  assign line_seq = line_q[LINE_SEQ_BIT];
  assign acyc_on = line_seq && line_q[LINE_ACYC_BIT];
  assign single_eff = mode_q[MODE_SINGLE_BIT] || line_seq;
  assign chan_eff = line_seq ? 2'h0 : chan_q;
  assign rs_active = compat && correlated_sampling;

  // ==========================================================
  // Channel routing and power
  always_comb begin
    channel_enable_o = 3'h7;
    if (single_eff) begin
      unique case (atc_chan_t'(chan_eff))
        ATC_RED: channel_enable_o = 3'h1;
        ATC_GREEN: channel_enable_o = 3'h2;
        ATC_BLUE: channel_enable_o = 3'h4;
        ATC_RSVD: channel_enable_o = 3'h1;
      endcase
    end
  end

  assign clamp_reference_code_o = clamp_q;
  assign correlated_sampling_o = correlated_sampling && !acyc_on;

  // ==========================================================
  // Output latency
  logic [4:0] lat_tap;

  assign lat_tap = atc_latency(lat_q, compat, cmode_q == COMPAT_MODE_LONG);
  assign half_period_o = compat;

  atc_delay_line #(
    .WIDTH(DATA_W),
    .DEPTH(LAT_DEPTH)
  ) u_delay (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clr_i(wr_soft),
    .tap_i(lat_tap),
    .data_i(adc_data_i),
    .data_o(out_data_o)
  );

  // ==========================================================
  // Pin synchronisers
  logic [2:0] vs_q;
  logic [2:0] cy_q;
  logic rs_edge, cy_edge;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vs_q <= 3'h0;
      cy_q <= 3'h0;
    end else begin
      vs_q <= {vs_q[1:0], pixel_sample_strobe_i};
      cy_q <= {cy_q[1:0], cycle_pulse_i};
    end
  end

  assign rs_edge = vs_q[1] && !vs_q[2];
  assign cy_edge = cy_q[1] && !cy_q[2];

  // ==========================================================
  // Reset sample placement
  logic [3:0] rs_q;
  logic [1:0] rs_tap;

  assign rs_tap = rs_active ? (shift_q + RS_BASE_TAP - 2'h1) : RS_BASE_TAP;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rs_q <= 4'h0;
    end else if (wr_soft) begin
      rs_q <= 4'h0;
    end else begin
      rs_q <= {rs_q[2:0], rs_edge};
    end
  end

  assign reset_sample_o = rs_q[rs_tap];

  // ==========================================================
  // Auto-cycle sequence counter
  logic [1:0] cyc_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_q <= 2'h0;
    end else if (wr_soft || wr_cyc) begin
      cyc_q <= 2'h0;
    end else if (acyc_on && cy_edge) begin
      cyc_q <= (cyc_q == 2'h2) ? 2'h0 : cyc_q + 2'h1;
    end
  end

  always_comb begin
    gain_set_sel_o = 2'h0;
    if (acyc_on) begin
      gain_set_sel_o = cyc_q;
    end else if (line_seq) begin
      gain_set_sel_o = line_q[LINE_INTM_LSB +: 2];
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      unique case (reg_addr_i)
        ADDR_MODE_CFG: reg_rdata_o <= mode_q;
        ADDR_OUT_REF_CFG: reg_rdata_o <= {lat_q, out_ref_q};
        ADDR_CLAMP_CFG: reg_rdata_o <= {chan_q, shift_q, clamp_q};
        ADDR_LINE_CFG: reg_rdata_o <= {4'h0, line_q};
        ADDR_STATUS: reg_rdata_o <= {1'b0, channel_enable_o, chan_eff, cyc_q};
        ADDR_COMPAT_MODE: reg_rdata_o <= {5'h00, cmode_q};
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ==========================================================
  // Checks
  logic [5:0] age_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      age_q <= 6'h00;
    end else if (wr_soft || wr_mode || wr_out || wr_clamp || wr_cmode) begin
      age_q <= 6'h00;
    end else if (age_q != 6'h3F) begin
      age_q <= age_q + 6'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_soft_write;
    reg_we_i && (reg_addr_i == ADDR_SOFT_RESET);
  endsequence

  property p_soft_reset;
    s_soft_write |=> (clamp_q == CLAMP_CODE_RST) && (shift_q == SHIFT_RST) && (lat_q == OUT_LAT_RST) && !compat;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left a field set");

  property p_clamp_write;
    wr_clamp |=> clamp_reference_code_o == $past(reg_wdata_i[3:0]);
  endproperty
  a_clamp_write: assert property (p_clamp_write) else $error("clamp code not taken");

  property p_hold;
    !reg_we_i |=> $stable(clamp_q) && $stable(lat_q) && $stable(mode_q);
  endproperty
  a_hold: assert property (p_hold) else $error("field changed without write");

  property p_lat_norm;
    (age_q > 6'h20) && !compat && (lat_q == 2'h0) |-> out_data_o == $past(adc_data_i, 7);
  endproperty
  a_lat_norm: assert property (p_lat_norm) else $error("normal latency wrong");

  property p_lat_long;
    (age_q > 6'h20) && compat && (cmode_q == COMPAT_MODE_LONG) && (lat_q == 2'h3) |->
      out_data_o == $past(adc_data_i, 31);
  endproperty
  a_lat_long: assert property (p_lat_long) else $error("long compat latency wrong");

  sequence s_strobe_quiet;
    rs_edge && !rs_active && (age_q > 6'h02);
  endsequence

  property p_rs_default;
    s_strobe_quiet |-> ##2 reset_sample_o;
  endproperty
  a_rs_default: assert property (p_rs_default) else $error("shift applied outside compat");

  property p_rs_late;
    rs_edge && rs_active && (shift_q == 2'h3) && (age_q > 6'h02) |-> ##4 reset_sample_o;
  endproperty
  a_rs_late: assert property (p_rs_late) else $error("two clock delay missing");

  property p_all_on;
    !single_eff |-> channel_enable_o == 3'h7;
  endproperty
  a_all_on: assert property (p_all_on) else $error("channel off outside single mode");

  property p_green;
    single_eff && (chan_eff == 2'h1) |-> channel_enable_o == 3'h2;
  endproperty
  a_green: assert property (p_green) else $error("green routing wrong");

  property p_cyc_reset;
    wr_cyc |=> gain_set_sel_o == 2'h0 || !acyc_on;
  endproperty
  a_cyc_reset: assert property (p_cyc_reset) else $error("cycle counter not cleared");

  property p_cyc_wrap;
    acyc_on && cy_edge && (cyc_q == 2'h2) && !reg_we_i |=> cyc_q == 2'h0;
  endproperty
  a_cyc_wrap: assert property (p_cyc_wrap) else $error("blue did not wrap to red");

  property p_cyc_step;
    acyc_on && cy_edge && (cyc_q != 2'h2) && !reg_we_i |=> cyc_q == $past(cyc_q) + 2'h1;
  endproperty
  a_cyc_step: assert property (p_cyc_step) else $error("cycle counter did not step");

  property p_rs_early;
    rs_edge && rs_active && (shift_q == 2'h0) && (age_q > 6'h02) |-> ##1 reset_sample_o;
  endproperty
  a_rs_early: assert property (p_rs_early) else $error("one clock advance missing");

  property p_lat_compat;
    (age_q > 6'h20) && compat && (cmode_q != COMPAT_MODE_LONG) && (lat_q == 2'h1) |->
      out_data_o == $past(adc_data_i, 18);
  endproperty
  a_lat_compat: assert property (p_lat_compat) else $error("compat latency wrong");

  property p_red;
    single_eff && (chan_eff == 2'h0) |-> channel_enable_o == 3'h1;
  endproperty
  a_red: assert property (p_red) else $error("red routing wrong");

  property p_blue;
    single_eff && (chan_eff == 2'h2) |-> channel_enable_o == 3'h4;
  endproperty
  a_blue: assert property (p_blue) else $error("blue routing wrong");

  property p_line_red;
    line_seq |-> channel_enable_o == 3'h1;
  endproperty
  a_line_red: assert property (p_line_red) else $error("line mode not on red alone");

endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
  import atc_pkg::*;
;
  typedef struct {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [3:0] clamp;
    logic [2:0] en;
  } atc_tb_row_t;

  // ==========================================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [15:0] adc_data_i = 16'h0000;
  logic pixel_sample_strobe_i = 1'b0;
  logic cycle_pulse_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [15:0] out_data_o;
  logic half_period_o;
  logic reset_sample_o;
  logic [1:0] gain_set_sel_o;
  logic [2:0] channel_enable_o;
  logic [3:0] clamp_reference_code_o;
  logic correlated_sampling_o;
  int n_errors = 0;
  int n_compared = 0;
  int tick = 0;
  logic [4:0] long_lat [4] = '{5'h17, 5'h1A, 5'h1D, 5'h1F};
  atc_tb_row_t rows [8] = '{
    '{8'h03, 8'h0A, 8'h0A, 4'hA, 3'h7},
    '{8'h01, 8'h04, 8'h04, 4'hA, 3'h1},
    '{8'h03, 8'h4A, 8'h4A, 4'hA, 3'h2},
    '{8'h03, 8'h8A, 8'h8A, 4'hA, 3'h4},
    '{8'h03, 8'h03, 8'h03, 4'h3, 3'h1},
    '{8'h02, 8'hC0, 8'hC0, 4'h3, 3'h1},
    '{8'h09, 8'h55, 8'h00, 4'h3, 3'h1},
    '{8'h01, 8'h00, 8'h00, 4'h3, 3'h7}
  };

  atc_timing_regs atc_timing_regs_inst (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o),
    .adc_data_i(adc_data_i),
    .out_data_o(out_data_o),
    .half_period_o(half_period_o),
    .pixel_sample_strobe_i(pixel_sample_strobe_i),
    .reset_sample_o(reset_sample_o),
    .cycle_pulse_i(cycle_pulse_i),
    .gain_set_sel_o(gain_set_sel_o),
    .channel_enable_o(channel_enable_o),
    .clamp_reference_code_o(clamp_reference_code_o),
    .correlated_sampling_o(correlated_sampling_o)
  );

  // ==========================================================
  // Clock, data ramp and run limit
  always #20 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    adc_data_i <= adc_data_i + 16'h0001;
    tick <= tick + 1;
    if (tick == 6000) begin
      n_errors++;
      stop_test();
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    @(negedge clk_i);
    chk("read data", 16'(e), 16'(reg_rdata_o));
  endtask

  task automatic chk_defaults();
    rd(ADDR_MODE_CFG, 8'h00);
    rd(ADDR_OUT_REF_CFG, 8'h20);
    rd(ADDR_CLAMP_CFG, 8'h1F);
    rd(ADDR_LINE_CFG, 8'h00);
    rd(ADDR_COMPAT_MODE, 8'h01);
    chk("clamp code", 16'h000F, 16'(clamp_reference_code_o));
    chk("channel enable", 16'h0007, 16'(channel_enable_o));
    chk("gain set", 16'h0000, 16'(gain_set_sel_o));
    chk("half period", 16'h0000, 16'(half_period_o));
  endtask

  task automatic lat(input logic [1:0] sel, input logic [4:0] exp_l, input logic hp);
    wr(ADDR_OUT_REF_CFG, {sel, 6'h20});
    repeat (40) @(posedge clk_i);
    @(negedge clk_i);
    chk("data latency", adc_data_i - 16'(exp_l), out_data_o);
    chk("half period", 16'(hp), 16'(half_period_o));
  endtask

  task automatic rsmp(input int exp_n);
    int n;
    n = 0;
    @(posedge clk_i);
    pixel_sample_strobe_i <= 1'b1;
    while (n < 12) begin
      @(posedge clk_i);
      n++;
      @(negedge clk_i);
      if (reset_sample_o === 1'b1) begin
        break;
      end
    end
    chk("reset sample delay", 16'(exp_n), 16'(n));
    @(negedge clk_i);
    chk("reset sample width", 16'h0000, 16'(reset_sample_o));
    @(posedge clk_i);
    pixel_sample_strobe_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic pulse();
    @(posedge clk_i);
    cycle_pulse_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    cycle_pulse_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    wr(ADDR_SOFT_RESET, 8'h00);
    chk_defaults();
    // Field table
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rexp);
      chk("clamp code", 16'(rows[i].clamp), 16'(clamp_reference_code_o));
      chk("channel enable", 16'(rows[i].en), 16'(channel_enable_o));
    end
    // Latency in all timing modes
    for (int m = 0; m < 3; m++) begin
      if (m == 0) begin
        wr(ADDR_MODE_CFG, 8'h00);
      end else begin
        wr(ADDR_MODE_CFG, 8'h80);
        wr(ADDR_COMPAT_MODE, (m == 1) ? 8'h01 : 8'h03);
      end
      for (int s = 0; s < 4; s++) begin
        if (m == 0) begin
          lat(2'(s), 5'(7 + s), 1'b0);
        end else if (m == 1) begin
          lat(2'(s), 5'(16 + 2 * s), 1'b1);
        end else begin
          lat(2'(s), long_lat[s], 1'b1);
        end
      end
    end
    // Reset sample position
    wr(ADDR_MODE_CFG, 8'h02);
    wr(ADDR_CLAMP_CFG, 8'h0F);
    rsmp(4);
    wr(ADDR_MODE_CFG, 8'h82);
    wr(ADDR_COMPAT_MODE, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CLAMP_CFG, {2'h0, 2'(c), 4'hF});
      rsmp(3 + c);
    end
    // Gain set selection and auto-cycle
    wr(ADDR_MODE_CFG, 8'h02);
    wr(ADDR_LINE_CFG, 8'h09);
    @(negedge clk_i);
    chk("gain set", 16'h0002, 16'(gain_set_sel_o));
    chk("channel enable", 16'h0001, 16'(channel_enable_o));
    chk("correlated sampling", 16'h0001, 16'(correlated_sampling_o));
    wr(ADDR_LINE_CFG, 8'h03);
    @(negedge clk_i);
    chk("gain set", 16'h0000, 16'(gain_set_sel_o));
    chk("correlated sampling", 16'h0000, 16'(correlated_sampling_o));
    for (int i = 1; i < 5; i++) begin
      pulse();
      chk("gain set", 16'(i % 3), 16'(gain_set_sel_o));
    end
    wr(ADDR_CYCLE_RESET, 8'hA7);
    @(negedge clk_i);
    chk("gain set", 16'h0000, 16'(gain_set_sel_o));
    pulse();
    chk("gain set", 16'h0001, 16'(gain_set_sel_o));
    rd(ADDR_STATUS, 8'h11);
    // Soft reset from a busy configuration
    wr(ADDR_CLAMP_CFG, 8'h96);
    wr(ADDR_OUT_REF_CFG, 8'hFF);
    wr(ADDR_SOFT_RESET, 8'h5A);
    @(negedge clk_i);
    chk_defaults();
    // Hardware reset in mid-run
    wr(ADDR_CLAMP_CFG, 8'h96);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(negedge clk_i);
    chk("out data", 16'h0000, out_data_o);
    chk_defaults();
    stop_test();
  end
endmodule
`default_nettype wire
